// file: core/tpl_pkg.sv
package tpl_pkg;
  localparam int POS_W = 32;
  localparam logic [2:0] SYNC_RST = 3'h0;
  localparam logic [31:0] POS_RST = 32'h0000_0000;
  localparam logic EDGE_RISE = 1'h1;
endpackage : tpl_pkg

// file: core/tpl_edge_if.sv
`timescale 1ns/1ps
interface tpl_edge_if;
  logic rise;
  logic fall;
  modport src (output rise, output fall);
  modport dst (input rise, input fall);
endinterface : tpl_edge_if

// file: core/tpl_probe_sync.sv
`timescale 1ns/1ps
module tpl_probe_sync (
  input wire logic sys_clk_i, // system clock
  input wire logic reset_i, // sync reset, active high
  input wire logic probe_fired_input_i, // raw probe pin
  tpl_edge_if.src edge_o // detected transitions
);
  logic [2:0] sync_q;
  // [R7] three-stage synchroniser
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
      sync_q <= tpl_pkg::SYNC_RST;
    else
      sync_q <= {sync_q[1:0], probe_fired_input_i};
  end
  // [R1] transitions only, stages two and three compared
  assign edge_o.rise = sync_q[1] & ~sync_q[2];
  assign edge_o.fall = ~sync_q[1] & sync_q[2];
endmodule : tpl_probe_sync

// file: core/tpl_latch.sv
`timescale 1ns/1ps
// Summary of operation
// [R1] only probe input transitions trigger; steady levels never do
// [R2] configuration selects rising or falling transition as trigger
// [R3] selected transition while armed stores present axis position
// [R4] after capture ignore transitions until software re-arms; position held
// [R5] position captured the cycle after the edge is detected
// [R6] probe should open relay on deflection so broken wire triggers
// [R7] probe input synchronised, then compared with previous sample
module tpl_latch (
  input wire logic sys_clk_i, // system clock, 20 MHz
  input wire logic reset_i, // sync reset, active high
  input wire logic probe_fired_input_i, // probe pin, asynchronous
  input wire logic edge_rise_i, // 1 rising, 0 falling trigger
  input wire logic rearm_i, // pulse: arm capture
  input wire logic [tpl_pkg::POS_W-1:0] axis_pos_i, // present axis position
  output logic [tpl_pkg::POS_W-1:0] latch_pos_o, // captured position
  output logic armed_o, // capture armed
  output logic captured_o // capture done, held till re-arm
);
  tpl_edge_if edges ();
  logic trig;
  logic armed_q;
  logic captured_q;
  logic [tpl_pkg::POS_W-1:0] pos_q;

  tpl_probe_sync u_sync (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .probe_fired_input_i(probe_fired_input_i),
    .edge_o(edges)
  );

  // [R2] active edge select
  assign trig = edge_rise_i ? edges.rise : edges.fall;

  // [R4] arming: capture disarms, re-arm pulse arms
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
      armed_q <= 1'h0;
    else if (rearm_i)
      armed_q <= 1'h1;
    else if (trig)
      armed_q <= 1'h0;
  end

  // [R3] store position on armed trigger, [R5] held in pos_q from the cycle after
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
      pos_q <= tpl_pkg::POS_RST;
    else if (armed_q && trig)
      pos_q <= axis_pos_i;
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
      captured_q <= 1'h0;
    else if (armed_q && trig)
      captured_q <= 1'h1;
    else if (rearm_i)
      captured_q <= 1'h0;
  end

  assign latch_pos_o = pos_q;
  assign armed_o = armed_q;
  assign captured_o = captured_q;

  a_capture_value: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    armed_q && trig |=> pos_q == $past(axis_pos_i)) // [R3]
    else $error("position not captured");
  a_hold_disarmed: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    !armed_q |=> pos_q == $past(pos_q)) // [R4]
    else $error("latched position changed while disarmed");
  a_disarm_trig: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    armed_q && trig && !rearm_i |=> !armed_q && captured_q) // [R4]
    else $error("trigger did not disarm");
  a_level_ignored: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    $stable(u_sync.sync_q[2]) && $stable(u_sync.sync_q[1])
      && u_sync.sync_q[1] == u_sync.sync_q[2] |-> !trig) // [R1]
    else $error("steady level triggered");
  a_edge_select: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    trig |-> (edge_rise_i ? u_sync.sync_q[1] : !u_sync.sync_q[1])) // [R2]
    else $error("wrong edge polarity");
  a_pin_latency: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    armed_q && !rearm_i && edge_rise_i && !u_sync.sync_q[2] && u_sync.sync_q[1]
      |=> captured_q) // [R5]
    else $error("capture latency exceeded");
  a_sync_compare: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    edges.rise |-> $past(u_sync.sync_q[1]) == 1'h0 && u_sync.sync_q[1]) // [R7]
    else $error("edge not from synchronised compare");
  a_rearm_arms: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    rearm_i |=> armed_q && !captured_q) // [R4]
    else $error("re-arm failed");

  c_capture_rise: cover property (@(posedge sys_clk_i) armed_q && trig && edge_rise_i);
  c_capture_fall: cover property (@(posedge sys_clk_i) armed_q && trig && !edge_rise_i);
  c_ignored_trig: cover property (@(posedge sys_clk_i) !armed_q && trig);
  c_rearm_after: cover property (@(posedge sys_clk_i) captured_q && rearm_i);
endmodule : tpl_latch

// file: verif/tpl_probe_model.sv
`timescale 1ns/1ps
module tpl_probe_model (
  input wire logic rest_i, // relay level at rest
  input wire logic fire_i, // stylus deflected
  output logic pin_o // probe relay output
);
  assign pin_o = rest_i ^ fire_i;
endmodule : tpl_probe_model

// file: verif/tb_touch_probe_position_latch.sv
`timescale 1ns/1ps
module tb_touch_probe_position_latch;
  logic sys_clk_i = 0, reset_i = 1, edge_rise_i = 1, rearm_i = 0, rest = 0, fire = 0;
  logic [31:0] axis_pos_i = 0, p;
  logic [31:0] latch_pos_o;
  logic armed_o, captured_o, pin;
  int err_total = 0, n_tests = 0;
  always #25 sys_clk_i = ~sys_clk_i;
  tpl_probe_model pm (.rest_i(rest), .fire_i(fire), .pin_o(pin));
  tpl_latch uut (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .probe_fired_input_i(pin),
    .edge_rise_i(edge_rise_i), .rearm_i(rearm_i), .axis_pos_i(axis_pos_i),
    .latch_pos_o(latch_pos_o), .armed_o(armed_o), .captured_o(captured_o));
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask : cyc
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e)
    begin
      err_total++;
      $display("ERROR %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic arm;
    rearm_i <= 1;
    cyc(1);
    rearm_i <= 0;
    cyc(3);
  endtask : arm
  task automatic final_report;
    $display("errors %0d checks %0d", err_total, n_tests);
    if (err_total == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : final_report
  initial
  begin
    void'($urandom(32'h8cd3));
    cyc(4);
    reset_i <= 0;
    for (int i = 0; i < 4; i++)
    begin
      edge_rise_i <= i[0];
      rest <= ~i[0];
      fire <= 0;
      cyc(6);
      arm();
      p = $urandom;
      axis_pos_i <= p;
      fire <= 1;
      cyc(4);
      chk(latch_pos_o, p);
      chk({captured_o, armed_o}, 32'h2);
      axis_pos_i <= $urandom;
      fire <= 0;
      cyc(5);
      fire <= 1;
      cyc(5);
      chk(latch_pos_o, p);
      arm();
      fire <= 0;
      cyc(12);
      chk({captured_o, armed_o}, 32'h1);
      p = axis_pos_i;
      fire <= 1;
      cyc(4);
      chk(latch_pos_o, p);
    end
    final_report();
  end
  initial
  begin
    #200000;
    err_total++;
    final_report();
  end
endmodule : tb_touch_probe_position_latch
